// ### logic/spio_ports.sv
// Shared parallel I/O block: seven ports, their registers and pin override paths.
// Assumes a single-cycle register port on mclk and pads outside that resolve oe_n.
//
// Summary of operation
// - Thirty-eight bonded general pins in seven ports A through G.
// - Pins not claimed by a peripheral are under general I/O control.
// - Reset leaves every pin under general I/O, peripherals not in control.
// - Reset clears every direction bit so all pins start as inputs.
// - Reset sets slew limit, clears drive strength and pullup enable.
// - Data and direction decode in zero page; pin controls in high page.
// - Port B pin used as analog input loses its general I/O function.
// - Timer three owns direction of its port B pins when enabled.
// - Serial two, IIC or clock out owns direction of its port C pins.
// - A peripheral driving a pin supplies the driven value, not the port.
// - Analog converter or keyboard unit owns direction of port D pins.
// - Analog converter wins over a digital peripheral on a shared pin.
// - Serial one, SPI or timer one owns direction of port E pins.
// - Timer one or two owns direction of its port F pins.
// - Data read gives pin level where the direction bit is clear, latch where set, on non-analog pins.
// - Data read gives zero for any pin under analog control.
// - Pullup is off on outputs and analog pins whatever its enable.
`timescale 1ns/1ns
`include "spio_consts.svh"

module spio_ports
	import spio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Peripheral claims, ports A to G at index 0 to 6.
	input wire spio_periph_t [6:0] periph,
	// Pins.
	input wire logic [6:0][7:0] pin_in,
	output spio_pad_t [6:0] pad,
	// Synchronised pin levels for the peripherals.
	output logic [6:0][7:0] pin_sync
);

	////////////////////////////////////////////////////////////////////////////////
	// Fixed pin masks.
	localparam logic [6:0][7:0] BOND = {`SPIO_BOND_G, `SPIO_BOND_F, `SPIO_BOND_E,
		`SPIO_BOND_D, `SPIO_BOND_C, `SPIO_BOND_B, `SPIO_BOND_A};
	localparam logic [6:0][7:0] FUNC = {`SPIO_FUNC_G, `SPIO_FUNC_F, `SPIO_FUNC_E,
		`SPIO_FUNC_D, `SPIO_FUNC_C, `SPIO_FUNC_B, `SPIO_FUNC_A};
	localparam logic [6:0][7:0] ANA = {`SPIO_ANA_G, `SPIO_ANA_F, `SPIO_ANA_E,
		`SPIO_ANA_D, `SPIO_ANA_C, `SPIO_ANA_B, `SPIO_ANA_A};

	logic [6:0][7:0] data_reg;
	logic [6:0][7:0] dir_reg;
	logic [6:0][7:0] pull_reg;
	logic [6:0][7:0] slew_reg;
	logic [6:0][7:0] drive_reg;
	logic [6:0][7:0] read_val;
	logic [7:0] rdata_next;
	spio_sel_t wsel;
	spio_sel_t rsel;
	logic [7:0] wdata_bonded;
	spio_periph_t [6:0] claim;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode, used for both strobes. Unmapped addresses come back invalid.
	function automatic spio_sel_t decode(input logic [7:0] addr);
		spio_sel_t s;
		s.valid = 1'b0;
		s.port = 3'h0;
		s.kind = SPIO_K_DATA;
		if (!addr[7]) begin
			// Zero page: two registers per port.
			s.port = addr[3:1];
			s.kind = (addr[0] == `SPIO_ZP_DIR_OFS) ? SPIO_K_DIR : SPIO_K_DATA;
			s.valid = (addr[6:4] == 3'h0) && (addr[3:1] <= `SPIO_PORT_LAST);
		end else begin
			// High page: three pin control registers per port.
			s.port = addr[4:2];
			case (addr[1:0])
				`SPIO_HP_PULL_OFS: s.kind = SPIO_K_PULL;
				`SPIO_HP_SLEW_OFS: s.kind = SPIO_K_SLEW;
				`SPIO_HP_DRIVE_OFS: s.kind = SPIO_K_DRIVE;
				default: s.kind = SPIO_K_DATA;
			endcase
			s.valid = (addr[6:5] == 2'h0) && (addr[4:2] <= `SPIO_PORT_LAST) &&
				(addr[1:0] != 2'h3);
		end
		return s;
	endfunction

	// Write hit on one register kind; shared by every register bank below.
	function automatic logic wr_hit(input spio_sel_t s, input logic wr, input spio_kind_t k);
		return wr && s.valid && (s.kind == k);
	endfunction

	assign wsel = decode(reg_addr);
	assign rsel = wsel;

	// Write data trimmed to the bonded pins, so reserved bits never hold a one.
	assign wdata_bonded = reg_wdata & BOND[wsel.port];

	// Claims are ignored while reset is high, so a peripheral that comes out of
	// reset late cannot take a pin before the port logic is in a known state.
	assign claim = reset ? '0 : periph;

	////////////////////////////////////////////////////////////////////////////////
	// Port data latches. Writes land even on inputs so the value is ready
	// before software turns the pin around to an output.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			data_reg <= {7{`SPIO_DATA_RST}};
		end else if (wr_hit(wsel, reg_wr, SPIO_K_DATA)) begin
			data_reg[wsel.port] <= wdata_bonded;
		end
	end

	// Direction bits; all inputs after reset.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dir_reg <= {7{`SPIO_DIR_RST}};
		end else if (wr_hit(wsel, reg_wr, SPIO_K_DIR)) begin
			dir_reg[wsel.port] <= wdata_bonded;
		end
	end

	// Pullup enables; off after reset.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pull_reg <= {7{`SPIO_PULL_RST}};
		end else if (wr_hit(wsel, reg_wr, SPIO_K_PULL)) begin
			pull_reg[wsel.port] <= wdata_bonded;
		end
	end

	// Slew limit; on for every bonded pin after reset.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			slew_reg <= BOND & {7{`SPIO_SLEW_RST}};
		end else if (wr_hit(wsel, reg_wr, SPIO_K_SLEW)) begin
			slew_reg[wsel.port] <= wdata_bonded;
		end
	end

	// Drive strength; low drive after reset.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			drive_reg <= {7{`SPIO_DRIVE_RST}};
		end else if (wr_hit(wsel, reg_wr, SPIO_K_DRIVE)) begin
			drive_reg[wsel.port] <= wdata_bonded;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses and reserved bits give zero.
	always_comb begin
		rdata_next = 8'h00;
		if (rsel.valid) begin
			case (rsel.kind)
				SPIO_K_DATA: rdata_next = read_val[rsel.port];
				SPIO_K_DIR: rdata_next = dir_reg[rsel.port];
				SPIO_K_PULL: rdata_next = pull_reg[rsel.port];
				SPIO_K_SLEW: rdata_next = slew_reg[rsel.port];
				SPIO_K_DRIVE: rdata_next = drive_reg[rsel.port];
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// Read data stands for exactly the cycle after the strobe, zero otherwise.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One cell per port. Claims are held off while reset is high, so every pin
	// starts as a general input; the cell masks claims by pin.
	genvar p;
	generate
		for (p = 0; p < `SPIO_NPORTS; p++) begin : g_port
			spio_port_cell u_cell (
				.mclk(mclk),
				.reset(reset),
				.bond_mask(BOND[p]),
				.func_mask(FUNC[p]),
				.ana_mask(ANA[p]),
				.data_val(data_reg[p]),
				.dir_val(dir_reg[p]),
				.pull_val(pull_reg[p]),
				.slew_val(slew_reg[p]),
				.drive_val(drive_reg[p]),
				.periph(claim[p]),
				.pin_in(pin_in[p]),
				.pad(pad[p]),
				.read_val(read_val[p]),
				.pin_sync(pin_sync[p])
			);
		end
	endgenerate

endmodule

// ### include/spio_consts.svh
// Constants for the shared parallel I/O ports: register map, reset values, pin masks.
// Assumes it is included by the package and the port logic; it holds definitions only.
`ifndef SPIO_CONSTS_SVH
`define SPIO_CONSTS_SVH

// Port count and last port index.
`define SPIO_NPORTS 7
`define SPIO_PORT_LAST 3'h6

// Zero page: data at port*2, direction at port*2+1.
`define SPIO_ZP_DATA_OFS 1'h0
`define SPIO_ZP_DIR_OFS 1'h1
// High page (address bit 7 set): base 8'h80 + port*4 + field offset.
`define SPIO_HP_PULL_OFS 2'h0
`define SPIO_HP_SLEW_OFS 2'h1
`define SPIO_HP_DRIVE_OFS 2'h2

// Reset values; slew reset is all ones, trimmed to the bonded pins.
`define SPIO_DATA_RST 8'h00
`define SPIO_DIR_RST 8'h00
`define SPIO_PULL_RST 8'h00
`define SPIO_SLEW_RST 8'hFF
`define SPIO_DRIVE_RST 8'h00

// Bonded pins per port, A to G.
`define SPIO_BOND_A 8'h87
`define SPIO_BOND_B 8'h0F
`define SPIO_BOND_C 8'h3F
`define SPIO_BOND_D 8'h0F
`define SPIO_BOND_E 8'hFF
`define SPIO_BOND_F 8'h73
`define SPIO_BOND_G 8'h7F

// Pins that a digital peripheral may claim, per port.
`define SPIO_FUNC_A 8'h00
`define SPIO_FUNC_B 8'h0C
`define SPIO_FUNC_C 8'h2F
`define SPIO_FUNC_D 8'h0C
`define SPIO_FUNC_E 8'hFF
`define SPIO_FUNC_F 8'h33
`define SPIO_FUNC_G 8'h7F

// Pins that the analog converter may claim, per port.
`define SPIO_ANA_A 8'h00
`define SPIO_ANA_B 8'h0F
`define SPIO_ANA_C 8'h00
`define SPIO_ANA_D 8'h0F
`define SPIO_ANA_E 8'h00
`define SPIO_ANA_F 8'h00
`define SPIO_ANA_G 8'h00

`endif

// ### include/spio_pkg.sv
// Types shared by the parallel I/O port logic and its bench.
// Assumes the constants header sits beside it in the include path.
`include "spio_consts.svh"

package spio_pkg;

	// Register kind selected by an address.
	typedef enum logic [2:0] {
		SPIO_K_DATA = 3'h0,
		SPIO_K_DIR = 3'h1,
		SPIO_K_PULL = 3'h2,
		SPIO_K_SLEW = 3'h3,
		SPIO_K_DRIVE = 3'h4
	} spio_kind_t;

	// Decoded register select.
	typedef struct packed {
		logic valid;
		logic [2:0] port;
		spio_kind_t kind;
	} spio_sel_t;

	// Peripheral claims on one port, one bit per pin.
	typedef struct packed {
		logic [7:0] func_en;
		logic [7:0] func_dir;
		logic [7:0] func_out;
		logic [7:0] analog_en;
	} spio_periph_t;

	// Pad controls of one port, one bit per pin.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] pull;
		logic [7:0] slew;
		logic [7:0] drive;
	} spio_pad_t;

endpackage

// ### logic/spio_port_cell.sv
// One eight-pin port: pin input synchroniser, peripheral override and pad control.
// Assumes its register values come from the port bank on the same clock.
`timescale 1ns/1ns

module spio_port_cell
	import spio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Fixed pin masks of this port.
	input wire logic [7:0] bond_mask,
	input wire logic [7:0] func_mask,
	input wire logic [7:0] ana_mask,
	// Register values.
	input wire logic [7:0] data_val,
	input wire logic [7:0] dir_val,
	input wire logic [7:0] pull_val,
	input wire logic [7:0] slew_val,
	input wire logic [7:0] drive_val,
	// Peripheral claims and pin levels.
	input wire spio_periph_t periph,
	input wire logic [7:0] pin_in,
	// Pad controls, read value and synchronised pin levels.
	output spio_pad_t pad,
	output logic [7:0] read_val,
	output logic [7:0] pin_sync
);

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] meta_reg;
	logic [7:0] sync_reg;
	logic [7:0] ana;
	logic [7:0] fn;
	logic [7:0] is_out;

	// Two flops before any logic sees a pin; only sync_reg reads meta_reg.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_reg <= 8'h00;
			sync_reg <= 8'h00;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog claims beat digital claims, so a digital enable is masked by analog.
	assign ana = periph.analog_en & ana_mask & bond_mask;
	assign fn = periph.func_en & func_mask & bond_mask & ~ana;

	// A claimed pin takes its direction from the peripheral, else from the port.
	assign is_out = ((fn & periph.func_dir) | (~fn & dir_val)) & ~ana & bond_mask;

	// Drive value and enables; unbonded bits never drive.
	always_comb begin
		pad.out = ((fn & periph.func_out) | (~fn & data_val)) & bond_mask;
		pad.oe_n = ~is_out;
		pad.pull = pull_val & ~is_out & ~ana & bond_mask;
		pad.slew = slew_val & bond_mask;
		pad.drive = drive_val & bond_mask;
	end

	// Readback follows the direction bit even while a digital peripheral owns the pin.
	assign read_val = ((dir_val & data_val) | (~dir_val & sync_reg)) & ~ana & bond_mask;
	assign pin_sync = sync_reg;

endmodule

// ### testbench/spio_ports_checker.sv
// Checker for the shared parallel I/O block, bound to its top module.
// Assumes peripheral claims stay low while reset is high.
`timescale 1ns/1ns

module spio_ports_checker
	import spio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Peripherals and pins.
	input wire spio_periph_t [6:0] periph,
	input wire logic [6:0][7:0] pin_in,
	input wire spio_pad_t [6:0] pad,
	input wire logic [6:0][7:0] pin_sync
);
	default clocking cb @(posedge mclk); endclocking
	////////////////////////////////////////////////////////////////////////////////
	// Reset state is watched while reset is high, so these two have no disable.
	property p_rst_dir;
		reset |-> (pad[1].oe_n & pad[4].oe_n & pad[5].oe_n) == 8'hFF;
	endproperty
	a_rst_dir: assert property (p_rst_dir) else $error("pin driven in reset");
	property p_rst_ctl;
		reset |-> pad[4].slew == 8'hFF && pad[4].drive == 8'h00 && pad[4].pull == 8'h00;
	endproperty
	a_rst_ctl: assert property (p_rst_ctl) else $error("pin control not at reset");
	////////////////////////////////////////////////////////////////////////////////
	// Read data stands one cycle only; stale data would hide a decode slip.
	property p_unmapped;
		disable iff (reset) (reg_rd && (reg_addr == 8'h0E || reg_addr == 8'h83)) || !reg_rd
			|=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("read data not zero");
	property p_unbond;
		disable iff (reset) reg_rd && reg_addr[7:1] == 7'h05 |=> (reg_rdata & 8'h8C) == 8'h00;
	endproperty
	a_unbond: assert property (p_unbond) else $error("unbonded bit read one");
	property p_ana_read;
		disable iff (reset) reg_rd && reg_addr == 8'h02 ##0 periph[1].analog_en[0] |=> !reg_rdata[0];
	endproperty
	a_ana_read: assert property (p_ana_read) else $error("analog pin read one");
	property p_dir_wr;
		disable iff (reset) reg_wr && reg_addr == 8'h09 ##1 periph[4].func_en == 8'h00
			|-> pad[4].oe_n == ~$past(reg_wdata);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction write not seen");
	////////////////////////////////////////////////////////////////////////////////
	// Override relations between claims and pads.
	property p_ana_pin;
		disable iff (reset) (periph[1].analog_en & ~pad[1].oe_n & 8'h0F) == 8'h00;
	endproperty
	a_ana_pin: assert property (p_ana_pin) else $error("analog pin driven");
	property p_tmr_dir;
		disable iff (reset) (periph[1].func_en & ~periph[1].analog_en & 8'h0C
			& (pad[1].oe_n ^ ~periph[1].func_dir)) == 8'h00;
	endproperty
	a_tmr_dir: assert property (p_tmr_dir) else $error("timer direction lost");
	property p_fn_out;
		disable iff (reset) ((pad[4].out ^ periph[4].func_out) & periph[4].func_en
			& periph[4].func_dir) == 8'h00;
	endproperty
	a_fn_out: assert property (p_fn_out) else $error("peripheral data not driven");
	property p_pull_off;
		disable iff (reset) ((pad[4].pull & ~pad[4].oe_n) | (pad[1].pull & periph[1].analog_en)) == 8'h00;
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pullup on while driving");
	c_ana_read: cover property (reg_rd && reg_addr == 8'h02 && periph[1].analog_en[0]);
	c_fn_out: cover property (|(periph[4].func_en & periph[4].func_dir));
	c_unmapped: cover property (reg_rd && reg_addr == 8'h83);
endmodule

bind spio_ports spio_ports_checker chk (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.periph(periph), .pin_in(pin_in), .pad(pad), .pin_sync(pin_sync));

// ### testbench/spio_board.sv
// Board model: resolves each pad against external drive and the pullup.
// Assumes the bench sets which pins the board drives and to what level.
`timescale 1ns/1ns

module spio_board
	import spio_pkg::*;
(
	// Clock for the floating pattern.
	input wire logic mclk,
	// Pads and board drive.
	input wire spio_pad_t [6:0] pad,
	input wire logic [6:0][7:0] ext_val,
	input wire logic [6:0][7:0] ext_en,
	output logic [6:0][7:0] pin_in
);
	logic tog = 1'b0;
	// A floating pin toggles so that no settled value can pass by luck.
	always @(posedge mclk) tog <= ~tog;
	always_comb begin
		for (int p = 0; p < 7; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (!pad[p].oe_n[b]) pin_in[p][b] = pad[p].out[b];
				else if (ext_en[p][b]) pin_in[p][b] = ext_val[p][b];
				else if (pad[p].pull[b]) pin_in[p][b] = 1'b1;
				else pin_in[p][b] = tog ^ b[0];
			end
		end
	end
endmodule

// ### testbench/spio_ports_tb.sv
// Self-checking bench for the shared parallel I/O block with a register model.
// Assumes the board model drives every pin that the block leaves as input.
`timescale 1ns/1ns
`include "spio_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end

module spio_ports_tb
	import spio_pkg::*;
;
	logic mclk = 1'b0, reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, fn, ana, oe, po, pv;
	spio_periph_t [6:0] periph = '0;
	spio_pad_t [6:0] pad;
	logic [6:0][7:0] pin_in, pin_sync, ext_val = '0, ext_en = '1;
	int mismatches = 0, checks_done = 0;
	logic [7:0] m [7][5];
	localparam logic [7:0] BOND [7] = '{`SPIO_BOND_A, `SPIO_BOND_B, `SPIO_BOND_C,
		`SPIO_BOND_D, `SPIO_BOND_E, `SPIO_BOND_F, `SPIO_BOND_G};
	localparam logic [7:0] FUNC [7] = '{`SPIO_FUNC_A, `SPIO_FUNC_B, `SPIO_FUNC_C,
		`SPIO_FUNC_D, `SPIO_FUNC_E, `SPIO_FUNC_F, `SPIO_FUNC_G};
	localparam logic [7:0] ANA [7] = '{`SPIO_ANA_A, `SPIO_ANA_B, `SPIO_ANA_C,
		`SPIO_ANA_D, `SPIO_ANA_E, `SPIO_ANA_F, `SPIO_ANA_G};
	always #5 mclk = ~mclk;
	spio_ports uut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph(periph),
		.pin_in(pin_in), .pad(pad), .pin_sync(pin_sync));
	spio_board board (.mclk(mclk), .pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks; each strobe is dropped one edge later, so no edge sees two drivers.
	function automatic logic [7:0] addr_of(int p, int k);
		return k < 2 ? 8'(p * 2 + k) : 8'(128 + p * 4 + k - 2);
	endfunction
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		periph <= '0;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		foreach (m[p, k]) m[p][k] = (k == 3) ? BOND[p] : 8'h00;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Pads and every register compared with the model; three edges let pins settle.
	task automatic check_all();
		repeat (3) @(posedge mclk);
		#1;
		for (int p = 0; p < 7; p++) begin
			ana = periph[p].analog_en & ANA[p] & BOND[p];
			fn = periph[p].func_en & FUNC[p] & BOND[p] & ~ana;
			oe = (fn & periph[p].func_dir | ~fn & m[p][1]) & ~ana;
			po = fn & periph[p].func_out | ~fn & m[p][0];
			pv = oe & po | ~oe & ext_val[p];
			`CHK(pad[p].oe_n, ~oe)
			`CHK(pad[p].out & oe, po & oe)
			`CHK(pad[p].pull, m[p][2] & ~oe & ~ana)
			`CHK(pad[p].slew, m[p][3])
			`CHK(pad[p].drive, m[p][4])
			`CHK(pin_sync[p], pv)
			rd(addr_of(p, 0));
			`CHK(v, (m[p][1] & m[p][0] | ~m[p][1] & pv) & BOND[p] & ~ana)
			for (int k = 1; k < 5; k++) begin
				rd(addr_of(p, k));
				`CHK(v, m[p][k])
			end
		end
		rd(8'h0E);
		`CHK(v, 8'h00)
		rd(8'h83);
		`CHK(v, 8'h00)
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, random traffic with overrides, reset after the traffic.
	initial begin
		void'($urandom(55219));
		do_reset();
		check_all();
		for (int it = 0; it < 20; it++) begin
			for (int p = 0; p < 7; p++) begin
				for (int k = 0; k < 5; k++) begin
					v = 8'($urandom);
					wr(addr_of(p, k), v);
					m[p][k] = v & BOND[p];
				end
				ext_val[p] <= 8'($urandom);
				if (it > 1) periph[p] <= spio_periph_t'($urandom);
			end
			wr(8'h83, 8'hFF);
			wr(8'h0E, 8'hFF);
			check_all();
		end
		@(posedge mclk);
		do_reset();
		check_all();
		complete_run();
	end
	initial begin
		#600000;
		mismatches++;
		complete_run();
	end
endmodule
